// ---- design/sld_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "sld_regs.vh"
module sld_top (
  input  wire                    ref_clk_i,
  input  wire                    rstn_i,
  input  wire                    ce_i,
  input  wire [7:0]              addr_i,
  input  wire [31:0]             wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [31:0]             rdata_o,
  input  wire                    fullstep_i,
  input  wire [`SLD_LOAD_W-1:0]  raw_load_i,
  input  wire [`SLD_TIME_W-1:0]  tstep_i,
  output reg                     ramp_stop_o,
  output reg                     vel_zero_o,
  output reg                     stall_o,
  output reg                     irq_o
);
  // ****************************************************
  // registers
  // ****************************************************
  reg                    stop_en_ff;
  reg                    filt_en_ff;
  reg [`SLD_OFS_W-1:0]   ofs_ff;
  reg [`SLD_TIME_W-1:0]  tlower_ff;
  reg [`SLD_TIME_W-1:0]  tupper_ff;
  reg [`SLD_LOAD_W-1:0]  load_ff;
  reg [`SLD_EVT_W-1:0]   status_ff;
  reg [`SLD_EVT_W-1:0]   irq_en_ff;
  reg                    stopped_ff;
  reg [31:0]             nxt_rdata;
  reg [`SLD_LOAD_W-1:0]  nxt_load;

  wire                   filt_valid;
  wire [`SLD_LOAD_W-1:0] filt_value;
  wire                   in_band;

  // ****************************************************
  // offset and clamp
  // ****************************************************
  // raw sample already falls with load; offset only shifts it
  wire signed [12:0] ofs_term = $signed({{6{ofs_ff[`SLD_OFS_W-1]}}, ofs_ff})
                                * $signed(13'h0004);
  wire signed [12:0] tuned    = $signed({3'h0, raw_load_i}) + ofs_term; // RULE2

  always @* begin
    if (tuned < 13'sh0000) begin
      nxt_load = 10'h000;
    end else if (tuned > $signed({3'h0, `SLD_LOAD_MAX})) begin
      nxt_load = `SLD_LOAD_MAX; // RULE4
    end else begin
      nxt_load = tuned[`SLD_LOAD_W-1:0]; // RULE1
    end
  end

  sld_filter u_filter (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .filt_en_i (filt_en_ff),
    .step_i    (fullstep_i),
    .sample_i  (nxt_load),
    .valid_o   (filt_valid),
    .value_o   (filt_value)
  );

  sld_vwin u_vwin (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .tstep_i   (tstep_i),
    .tlower_i  (tlower_ff),
    .tupper_i  (tupper_ff),
    .in_band_o (in_band)
  );

  // ****************************************************
  // stall detection and stop
  // ****************************************************
  wire stall_hit = filt_valid && (filt_value == 10'h000) && in_band; // RULE7
  wire stop_evt  = stall_hit && stop_en_ff && !stopped_ff; // RULE5
  wire wr_clr    = wr_i && (addr_i == `SLD_ADDR_CLEAR);
  wire wr_ctrl   = wr_i && (addr_i == `SLD_ADDR_CTRL);
  wire clr_stop  = wr_clr && wdata_i[`SLD_ST_STOP_BIT];
  wire ctrl_off  = wr_ctrl && !wdata_i[`SLD_CTRL_STOP_BIT];

  wire [`SLD_EVT_W-1:0] set_vec = {filt_valid, stop_evt};
  wire [`SLD_EVT_W-1:0] clr_vec = wr_clr ? wdata_i[`SLD_EVT_W-1:0]
                                         : 2'h0;
  // set wins over a clear in the same cycle
  wire [`SLD_EVT_W-1:0] nxt_status = (status_ff & ~clr_vec) | set_vec;

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_en_ff  <= 1'b0;
      filt_en_ff  <= 1'b0;
      ofs_ff      <= 7'h00;
      tlower_ff   <= `SLD_RST_TLOWER;
      tupper_ff   <= `SLD_RST_TUPPER;
      load_ff     <= `SLD_LOAD_MAX;
      status_ff   <= 2'h0;
      irq_en_ff   <= 2'h0;
      stopped_ff  <= 1'b0;
      ramp_stop_o <= 1'b0;
      vel_zero_o  <= 1'b0;
      stall_o     <= 1'b0;
      irq_o       <= 1'b0;
      rdata_o     <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        stop_en_ff <= wdata_i[`SLD_CTRL_STOP_BIT];
        filt_en_ff <= wdata_i[`SLD_CTRL_FILT_BIT];
        ofs_ff     <= wdata_i[`SLD_CTRL_OFS_MSB:`SLD_CTRL_OFS_LSB];
      end
      if (wr_i && (addr_i == `SLD_ADDR_TLOWER)) begin
        tlower_ff <= wdata_i[`SLD_TIME_W-1:0];
      end
      if (wr_i && (addr_i == `SLD_ADDR_TUPPER)) begin
        tupper_ff <= wdata_i[`SLD_TIME_W-1:0];
      end
      if (wr_i && (addr_i == `SLD_ADDR_IRQ_EN)) begin
        irq_en_ff <= wdata_i[`SLD_EVT_W-1:0];
      end
      if (filt_valid) begin
        load_ff <= filt_value; // RULE9
        stall_o <= stall_hit;
      end
      status_ff <= nxt_status; // RULE11
      if (stop_evt) begin
        stopped_ff <= 1'b1; // RULE11
      end else if (clr_stop || ctrl_off) begin
        stopped_ff <= 1'b0; // RULE6
      end
      ramp_stop_o <= stop_evt || (stopped_ff && !clr_stop && !ctrl_off); // RULE10
      vel_zero_o  <= stop_evt || (stopped_ff && !clr_stop && !ctrl_off); // RULE10
      irq_o       <= |(nxt_status & irq_en_ff);
      rdata_o     <= rd_i ? nxt_rdata : 32'h0000_0000;
    end
  end

  // ****************************************************
  // read decode
  // ****************************************************
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (addr_i == `SLD_ADDR_CTRL) begin
      nxt_rdata[`SLD_CTRL_STOP_BIT] = stop_en_ff;
      nxt_rdata[`SLD_CTRL_FILT_BIT] = filt_en_ff;
      nxt_rdata[`SLD_CTRL_OFS_MSB:`SLD_CTRL_OFS_LSB] = ofs_ff;
    end else if (addr_i == `SLD_ADDR_TLOWER) begin
      nxt_rdata[`SLD_TIME_W-1:0] = tlower_ff;
    end else if (addr_i == `SLD_ADDR_TUPPER) begin
      nxt_rdata[`SLD_TIME_W-1:0] = tupper_ff;
    end else if (addr_i == `SLD_ADDR_LOAD) begin
      nxt_rdata[`SLD_LOAD_W-1:0] = load_ff; // RULE4
      nxt_rdata[`SLD_LOAD_STALL_BIT] = stall_o;
    end else if (addr_i == `SLD_ADDR_STATUS) begin
      nxt_rdata[`SLD_EVT_W-1:0] = status_ff;
    end else if (addr_i == `SLD_ADDR_IRQ_EN) begin
      nxt_rdata[`SLD_EVT_W-1:0] = irq_en_ff;
    end
  end
endmodule
`default_nettype wire

// ---- design/sld_regs.vh ----
// Overview of operation
// RULE1: reading falls as motor load rises
// RULE2: signed offset tunes stall sensitivity, zero neutral
// RULE3: filter bit gives one reading per four fullsteps
// RULE4: reading unsigned 0..1023, zero is highest load
// RULE5: stop-on-stall halts ramp when reading hits zero
// RULE6: clearing enable or event flag releases motor
// RULE7: no detection outside lower/upper velocity band
// RULE8: velocity band derived from step-time thresholds
// RULE9: unfiltered reading refreshes every fullstep
// RULE10: stall stop halts motion, forces velocity zero
// RULE11: sticky stall event holds motor until cleared
`ifndef SLD_REGS_VH
`define SLD_REGS_VH
// ****************************************************
// register offsets
// ****************************************************
`define SLD_ADDR_CTRL     8'h00
`define SLD_ADDR_TLOWER   8'h04
`define SLD_ADDR_TUPPER   8'h08
`define SLD_ADDR_LOAD     8'h0C
`define SLD_ADDR_STATUS   8'h10
`define SLD_ADDR_CLEAR    8'h14
`define SLD_ADDR_IRQ_EN   8'h18
// ****************************************************
// field positions and widths
// ****************************************************
`define SLD_CTRL_STOP_BIT 0
`define SLD_CTRL_FILT_BIT 1
`define SLD_CTRL_OFS_LSB  8
`define SLD_CTRL_OFS_MSB  14
`define SLD_ST_STOP_BIT   0
`define SLD_ST_UPD_BIT    1
`define SLD_LOAD_STALL_BIT 16
`define SLD_LOAD_W        10
`define SLD_OFS_W         7
`define SLD_TIME_W        20
`define SLD_EVT_W         2
`define SLD_OFS_SCALE     4
`define SLD_LOAD_MAX      10'h3FF
// ****************************************************
// reset values and timing
// ****************************************************
`define SLD_RST_CTRL      32'h0000_0000
`define SLD_RST_TLOWER    20'h00000
`define SLD_RST_TUPPER    20'h00000
`define SLD_FILT_STEPS    3'h4
`endif

// ---- design/sld_filter.v ----
`timescale 1ns/1ns
`default_nettype none
`include "sld_regs.vh"
module sld_filter (
  input  wire                    ref_clk_i,
  input  wire                    rstn_i,
  input  wire                    ce_i,
  input  wire                    filt_en_i,
  input  wire                    step_i,
  input  wire [`SLD_LOAD_W-1:0]  sample_i,
  output reg                     valid_o,
  output reg  [`SLD_LOAD_W-1:0]  value_o
);
  reg [`SLD_LOAD_W+1:0] acc_ff;
  reg [2:0]             cnt_ff;
  wire [`SLD_LOAD_W+1:0] nxt_acc = acc_ff + {2'h0, sample_i};

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_ff  <= 12'h000;
      cnt_ff  <= 3'h0;
      valid_o <= 1'b0;
      value_o <= 10'h3FF;
    end else if (ce_i) begin
      valid_o <= 1'b0;
      if (step_i) begin
        if (!filt_en_i) begin
          valid_o <= 1'b1; // RULE9
          value_o <= sample_i;
          acc_ff  <= 12'h000;
          cnt_ff  <= 3'h0;
        end else if (cnt_ff == `SLD_FILT_STEPS - 3'h1) begin
          valid_o <= 1'b1; // RULE3
          value_o <= nxt_acc[`SLD_LOAD_W+1:2];
          acc_ff  <= 12'h000;
          cnt_ff  <= 3'h0;
        end else begin
          acc_ff <= nxt_acc;
          cnt_ff <= cnt_ff + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/sld_vwin.v ----
`timescale 1ns/1ns
`default_nettype none
`include "sld_regs.vh"
module sld_vwin (
  input  wire                    ref_clk_i,
  input  wire                    rstn_i,
  input  wire                    ce_i,
  input  wire [`SLD_TIME_W-1:0]  tstep_i,
  input  wire [`SLD_TIME_W-1:0]  tlower_i,
  input  wire [`SLD_TIME_W-1:0]  tupper_i,
  output reg                     in_band_o
);
  // step time is inverse velocity: long time means slow motion
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_band_o <= 1'b0;
    end else if (ce_i) begin
      in_band_o <= (tstep_i <= tlower_i) && (tstep_i >= tupper_i); // RULE7 RULE8
    end
  end
endmodule
`default_nettype wire

// ---- dv/sld_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sld_regs.vh"
// ****
// stall stop checks
// ****
module sld_top_sva (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        fullstep_i,
  input wire logic        ramp_stop_o,
  input wire logic        vel_zero_o,
  input wire logic        stall_o
);
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire clr_w = wr_i && addr_i == `SLD_ADDR_CLEAR && wdata_i[0];
  wire off_w = wr_i && addr_i == `SLD_ADDR_CTRL && !wdata_i[0];
  wire lrd_w = rd_i && addr_i == `SLD_ADDR_LOAD;
  vel_zero_a: assert property (vel_zero_o == ramp_stop_o)
    else $error("velocity zero differs from stop");
  stop_stall_a: assert property ($rose(ramp_stop_o) |-> stall_o)
    else $error("stop without stall");
  stop_cause_a: assert property (
    $rose(ramp_stop_o) |-> $past(fullstep_i, 2))
    else $error("stop not two cycles after fullstep");
  stall_step_a: assert property (
    $changed(stall_o) |-> $past(fullstep_i, 2))
    else $error("stall changed without reading");
  stop_hold_a: assert property (
    ramp_stop_o && !wr_i |=> ramp_stop_o)
    else $error("stop dropped without write");
  clr_rel_a: assert property (ramp_stop_o && clr_w |=> !ramp_stop_o)
    else $error("clear did not release");
  ctrl_rel_a: assert property (off_w |=> !ramp_stop_o)
    else $error("disable did not release");
  load_bit_a: assert property (
    lrd_w |=> rdata_o[16] == $past(stall_o))
    else $error("stall bit differs in load read");
endmodule
bind sld_top sld_top_sva chk_u (
  .ref_clk_i   (ref_clk_i),
  .rstn_i      (rstn_i),
  .addr_i      (addr_i),
  .wdata_i     (wdata_i),
  .wr_i        (wr_i),
  .rd_i        (rd_i),
  .rdata_o     (rdata_o),
  .fullstep_i  (fullstep_i),
  .ramp_stop_o (ramp_stop_o),
  .vel_zero_o  (vel_zero_o),
  .stall_o     (stall_o)
);
`default_nettype wire

// ---- dv/sld_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sld_regs.vh"
// ****
// stall detection bench
// ****
module sld_top_tb;
  logic        ref_clk_i, rstn_i, ce_i, wr_i, rd_i, fullstep_i;
  logic        ramp_stop_o, vel_zero_o, stall_o, irq_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, v;
  logic [9:0]  raw_load_i;
  logic [19:0] tstep_i;
  int          fail_count, samples_checked;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h1C};
  logic [31:0] tw [5] = '{32'h0, 32'h300, 32'h3F00, 32'h4000, 32'h7F00};
  logic [9:0]  tr [5] = '{10'h100, 10'h100, 10'h3F0, 10'h80, 10'h10};
  logic [31:0] te [5] = '{32'h100, 32'h10C, 32'h3FF, 32'h10000, 32'hC};
  logic [19:0] bt [4] = '{20'h7D0, 20'h5, 20'h3E8, 20'hA};
  sld_top dut_u (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rdata_o     (rdata_o),
    .fullstep_i  (fullstep_i),
    .raw_load_i  (raw_load_i),
    .tstep_i     (tstep_i),
    .ramp_stop_o (ramp_stop_o),
    .vel_zero_o  (vel_zero_o),
    .stall_o     (stall_o),
    .irq_o       (irq_o)
  );
  initial begin
    ref_clk_i = 0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    wr_i <= 0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    rd_i <= 0;
    @(negedge ref_clk_i);
    v = rdata_o;
  endtask
  // tstep leads the pulse by a cycle since the band is registered
  task step(input logic [9:0] r, input logic [19:0] ts);
    @(posedge ref_clk_i);
    tstep_i <= ts;
    @(posedge ref_clk_i);
    {fullstep_i, raw_load_i} <= {1'b1, r};
    @(posedge ref_clk_i);
    fullstep_i <= 0;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task t_reset;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk("reset reg", v, 32'h0);
    end
    rd(`SLD_ADDR_LOAD);
    chk("reset load", v, 32'h3FF);
  endtask
  task t_tune;
    for (int i = 0; i < 5; i++) begin
      wr(`SLD_ADDR_CTRL, tw[i]);
      step(tr[i], 20'h64);
      rd(`SLD_ADDR_LOAD);
      chk("load", v, te[i]);
      chk("no stop", ramp_stop_o, 1'b0);
      rd(`SLD_ADDR_CTRL);
      chk("ctrl", v, tw[i]);
    end
  endtask
  task t_filter;
    wr(`SLD_ADDR_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      step(10'h64 * (i + 1), 20'h64);
      rd(`SLD_ADDR_LOAD);
      chk("filtered", v, i < 3 ? 32'hC : 32'hFA);
    end
  endtask
  task t_stall;
    wr(`SLD_ADDR_CTRL, 32'h1);
    wr(`SLD_ADDR_IRQ_EN, 32'h1);
    step(10'h0, 20'h64);
    chk("stop", {ramp_stop_o, vel_zero_o, stall_o, irq_o}, 4'hF);
    rd(`SLD_ADDR_STATUS);
    chk("event", v, 32'h3);
    wr(`SLD_ADDR_IRQ_EN, 32'h0);
    chk("irq masked", irq_o, 1'b0);
    wr(`SLD_ADDR_IRQ_EN, 32'h1);
    step(10'h200, 20'h64);
    chk("held", {ramp_stop_o, stall_o, irq_o}, 3'h5);
    wr(`SLD_ADDR_CLEAR, 32'h1);
    chk("clear", {ramp_stop_o, irq_o}, 2'h0);
    rd(`SLD_ADDR_STATUS);
    chk("event cleared", v, 32'h2);
    wr(`SLD_ADDR_CLEAR, 32'h2);
    rd(`SLD_ADDR_STATUS);
    chk("reading cleared", v, 32'h0);
    step(10'h0, 20'h64);
    chk("restop", ramp_stop_o, 1'b1);
    wr(`SLD_ADDR_CTRL, 32'h0);
    chk("disable", ramp_stop_o, 1'b0);
  endtask
  task t_band;
    rd(`SLD_ADDR_TLOWER);
    chk("lower limit", v, 32'h3E8);
    rd(`SLD_ADDR_TUPPER);
    chk("upper limit", v, 32'hA);
    for (int i = 0; i < 4; i++) begin
      step(10'h0, bt[i]);
      chk("band", stall_o, i > 1);
    end
  endtask
  // a fullstep while the enable is low must leave every state alone
  task t_freeze;
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    step(10'h200, 20'h64);
    chk("frozen stall", stall_o, 1'b1);
    @(posedge ref_clk_i);
    ce_i <= 1'b1;
    rd(`SLD_ADDR_LOAD);
    chk("frozen load", v, 32'h10000);
  endtask
  task t_midreset;
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("rst out", {ramp_stop_o, vel_zero_o, stall_o, irq_o}, 4'h0);
    t_reset();
  endtask
  initial begin
    {rstn_i, wr_i, rd_i, fullstep_i, addr_i, wdata_i} = 0;
    {raw_load_i, tstep_i, ce_i} = 1;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1;
    t_reset();
    wr(`SLD_ADDR_TLOWER, 32'h3E8);
    wr(`SLD_ADDR_TUPPER, 32'hA);
    t_tune();
    t_filter();
    t_stall();
    t_band();
    t_freeze();
    t_midreset();
    conclude();
  end
  initial begin
    #5000000;
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
